// ===== core/dpsf_pkg.sv
// Shared constants and types for the semaphore flag port controller.
`default_nettype none
package dpsf_pkg;
  localparam int FLAG_COUNT = 8;
  localparam int FLAG_IDX_W = 3;
  localparam logic [FLAG_IDX_W-1:0] FLAG_FIRST = 3'h0;
  localparam logic [FLAG_IDX_W-1:0] FLAG_LAST = 3'h7;
  localparam logic FLAG_FREE = 1'h1;
  localparam logic FLAG_TAKEN = 1'h0;
  localparam int PIN_ADDR_W = 16;
  localparam int PIN_DATA_W = 16;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ACCESS_TIME_PS = 16000;
  localparam int GAP_TIME_PS = 8000;
  // Least times round up to whole cycles.
  localparam int ACCESS_CYC = (ACCESS_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_CYC = (GAP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POLL_LIMIT = 4;

  typedef enum logic [1:0] {
    OP_INIT,
    OP_ACQUIRE,
    OP_RELEASE
  } dpsf_op_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_GAP,
    ST_RESP
  } dpsf_state_e;

  typedef struct packed {
    dpsf_op_e op;
    logic [FLAG_IDX_W-1:0] flag;
  } dpsf_cmd_s;

  typedef struct packed {
    logic ramSelN;
    logic tokenSelN;
    logic rwN;
    logic oeN;
    logic [PIN_ADDR_W-1:0] addr;
    logic [PIN_DATA_W-1:0] dataOut;
    logic dataOeN;
  } dpsf_pins_s;
endpackage : dpsf_pkg
`default_nettype wire

// ===== core/dpsf_cycle_timer.sv
// Down-counter that marks the last cycle of a timed pin phase.
`default_nettype none
module dpsf_cycle_timer #(
  parameter int CntW = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [CntW-1:0] count,
  output logic done
);
  logic runReg;
  logic runNext;
  logic [CntW-1:0] cntReg;
  logic [CntW-1:0] cntNext;

  // A zero-width counter cannot mark any phase, so such a build is refused.
  if (CntW < 1)
  begin : g_bad_width
    $error("dpsf_cycle_timer: CntW must be at least 1");
  end

  assign done = runReg && (cntReg == '0);

  always_comb
  begin
    runNext = runReg;
    cntNext = cntReg;
    if (start)
    begin
      runNext = 1'b1;
      cntNext = count - 1'b1;
    end
    else if (done)
    begin
      runNext = 1'b0;
    end
    else if (runReg)
    begin
      cntNext = cntReg - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      runReg <= 1'b0;
      cntReg <= '0;
    end
    else if (ce)
    begin
      runReg <= runNext;
      cntReg <= cntNext;
    end
  end
endmodule : dpsf_cycle_timer
`default_nettype wire

// ===== core/dpsf_port_ctrl.sv
// Controller that drives one port of a dual-port RAM's semaphore flag space.
`default_nettype none
// Behaviour
// - Flags are active low: write zero to request, one to release.
// - Between polling reads, drop select or output enable.
// - Acquire by writing zero then reading back; zero means success.
// - After a failed request keep reading or write one to withdraw.
// - At power-up write one to every flag location.
module dpsf_port_ctrl
  import dpsf_pkg::*;
#(
  parameter int AccessCycles = dpsf_pkg::ACCESS_CYC,
  parameter int GapCycles = dpsf_pkg::GAP_CYC,
  parameter int MaxPolls = dpsf_pkg::POLL_LIMIT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire dpsf_pkg::dpsf_cmd_s cmd,
  output logic rspValid,
  output logic rspGranted,
  output dpsf_pkg::dpsf_pins_s pins,
  input wire logic [dpsf_pkg::PIN_DATA_W-1:0] dataIn
);
  import dpsf_pkg::*;

  localparam int CntMax = (AccessCycles > GapCycles) ? AccessCycles : GapCycles;
  localparam int CntW = $clog2(CntMax + 1);
  localparam int PollW = $clog2(MaxPolls + 1);

  // Zero-length phases would wrap the timer count to all ones and stretch the phase instead of skipping it.
  if (AccessCycles < 1 || GapCycles < 1 || MaxPolls < 1)
  begin : g_bad_params
    $error("dpsf_port_ctrl: AccessCycles, GapCycles and MaxPolls must each be at least 1");
  end

  dpsf_state_e stateReg;
  dpsf_state_e stateNext;
  dpsf_op_e opReg;
  dpsf_op_e opNext;
  logic [FLAG_IDX_W-1:0] idxReg;
  logic [FLAG_IDX_W-1:0] idxNext;
  logic wrValReg;
  logic wrValNext;
  logic afterReadReg;
  logic afterReadNext;
  logic grantReg;
  logic grantNext;
  logic [PollW-1:0] pollReg;
  logic [PollW-1:0] pollNext;
  dpsf_pins_s pinsReg;
  dpsf_pins_s pinsNext;
  logic timerStart;
  logic timerDone;
  logic [CntW-1:0] timerCount;

  dpsf_cycle_timer #(
    .CntW(CntW)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(timerStart),
    .count(timerCount),
    .done(timerDone)
  );

  always_comb
  begin
    stateNext = stateReg;
    opNext = opReg;
    idxNext = idxReg;
    wrValNext = wrValReg;
    afterReadNext = afterReadReg;
    grantNext = grantReg;
    pollNext = pollReg;
    case (stateReg)
      ST_IDLE:
      begin
        if (cmdValid)
        begin
          opNext = cmd.op;
          idxNext = (cmd.op == OP_INIT) ? FLAG_FIRST : cmd.flag;
          wrValNext = (cmd.op == OP_ACQUIRE) ? FLAG_TAKEN : FLAG_FREE;
          grantNext = 1'b0;
          pollNext = '0;
          afterReadNext = 1'b0;
          stateNext = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        if (timerDone)
        begin
          afterReadNext = 1'b0;
          stateNext = ST_GAP;
        end
      end
      ST_READ:
      begin
        if (timerDone)
        begin
          // Any replicated bit carries the flag; bit zero is enough.
          grantNext = (dataIn[0] == FLAG_TAKEN);
          afterReadNext = 1'b1;
          stateNext = ST_GAP;
        end
      end
      ST_GAP:
      begin
        if (timerDone)
        begin
          case (opReg)
            OP_INIT:
            begin
              if (idxReg == FLAG_LAST)
              begin
                grantNext = 1'b1;
                stateNext = ST_RESP;
              end
              else
              begin
                idxNext = idxReg + 1'b1;
                stateNext = ST_WRITE;
              end
            end
            OP_ACQUIRE:
            begin
              if (!afterReadReg)
              begin
                stateNext = (wrValReg == FLAG_TAKEN) ? ST_READ : ST_RESP;
              end
              else if (grantReg)
              begin
                stateNext = ST_RESP;
              end
              else if (pollReg < PollW'(MaxPolls))
              begin
                pollNext = pollReg + 1'b1;
                stateNext = ST_READ;
              end
              else
              begin
                // A stale request would hand the flag to us later and hang the peer.
                wrValNext = FLAG_FREE;
                stateNext = ST_WRITE;
              end
            end
            default:
            begin
              grantNext = 1'b1;
              stateNext = ST_RESP;
            end
          endcase
        end
      end
      ST_RESP:
      begin
        stateNext = ST_IDLE;
      end
      default:
      begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  assign timerStart = (stateNext != stateReg) &&
                      (stateNext == ST_WRITE || stateNext == ST_READ || stateNext == ST_GAP);
  assign timerCount = (stateNext == ST_GAP) ? CntW'(GapCycles) : CntW'(AccessCycles);

  // Pins follow the next state so that they change together with stateReg.
  always_comb
  begin
    pinsNext.ramSelN = 1'b1;
    pinsNext.tokenSelN = !(stateNext == ST_WRITE || stateNext == ST_READ);
    pinsNext.rwN = (stateNext != ST_WRITE);
    pinsNext.oeN = (stateNext != ST_READ);
    pinsNext.addr = {{(PIN_ADDR_W-FLAG_IDX_W){1'b0}}, idxNext};
    pinsNext.dataOut = {PIN_DATA_W{wrValNext}};
    pinsNext.dataOeN = (stateNext != ST_WRITE);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stateReg <= ST_IDLE;
      opReg <= OP_INIT;
      idxReg <= FLAG_FIRST;
      wrValReg <= FLAG_FREE;
      afterReadReg <= 1'b0;
      grantReg <= 1'b0;
      pollReg <= '0;
      pinsReg <= '{ramSelN: 1'b1, tokenSelN: 1'b1, rwN: 1'b1, oeN: 1'b1, addr: '0, dataOut: '1, dataOeN: 1'b1};
    end
    else if (ce)
    begin
      stateReg <= stateNext;
      opReg <= opNext;
      idxReg <= idxNext;
      wrValReg <= wrValNext;
      afterReadReg <= afterReadNext;
      grantReg <= grantNext;
      pollReg <= pollNext;
      pinsReg <= pinsNext;
    end
  end

  assign pins = pinsReg;
  assign cmdReady = (stateReg == ST_IDLE);
  assign rspValid = (stateReg == ST_RESP);
  assign rspGranted = grantReg;

  // Helper: marks that the zero write of the current acquire has been issued.
  logic acqWroteReg;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      acqWroteReg <= 1'b0;
    else if (ce)
      acqWroteReg <= (stateReg == ST_IDLE) ? 1'b0 :
                     (acqWroteReg || (stateReg == ST_WRITE && wrValReg == FLAG_TAKEN));
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_read_end;
    !pins.oeN ##1 pins.oeN;
  endsequence

  sequence s_read_start;
    pins.oeN ##1 !pins.oeN;
  endsequence

  chk_select_dropped: assert property (s_read_end |-> pins.tokenSelN)
    else $error("select still active after a flag read");
  chk_read_from_idle: assert property (s_read_start |-> $past(pins.tokenSelN))
    else $error("flag read started without a select gap");
  chk_write_before_read: assert property ((stateReg == ST_READ) |-> acqWroteReg)
    else $error("flag read before the zero write");
  chk_release_writes_one: assert property ((!pins.rwN && opReg == OP_RELEASE) |->
      (pins.dataOut[0] == FLAG_FREE && !pins.dataOeN && !pins.tokenSelN))
    else $error("release did not write one on the selected flag");
  chk_acquire_writes_zero: assert property ((!pins.rwN && opReg == OP_ACQUIRE && !afterReadReg) |->
      pins.dataOut[0] == FLAG_TAKEN)
    else $error("acquire request did not write zero");
  chk_fail_withdrawn: assert property ((rspValid && opReg == OP_ACQUIRE && !rspGranted) |->
      (wrValReg == FLAG_FREE && pollReg == PollW'(MaxPolls)))
    else $error("failed acquire left a pending request");
  chk_init_all_ones: assert property ((!pins.rwN && opReg == OP_INIT) |-> pins.dataOut == '1)
    else $error("initialisation wrote a zero");
  chk_init_covers_all: assert property ((rspValid && opReg == OP_INIT) |-> idxReg == FLAG_LAST)
    else $error("initialisation ended before the last flag");
endmodule : dpsf_port_ctrl
`default_nettype wire

// ===== tb/dpsf_sem_model.sv
// Behavioural flag device: left port on the controller pins, right port driven by the bench.
`default_nettype none
module dpsf_sem_model
  import dpsf_pkg::*;
(
  input wire logic clk,
  input wire dpsf_pkg::dpsf_pins_s pins,
  output logic [dpsf_pkg::PIN_DATA_W-1:0] dataIn,
  input wire logic rSelN,
  input wire logic rWrN,
  input wire logic rOeN,
  input wire logic [dpsf_pkg::FLAG_IDX_W-1:0] rIdx,
  input wire logic rBit,
  output logic rFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  // There is no reset, so power-up leaves stale requests and the left side owning every flag.
  logic [7:0] reqL = 8'h00;
  logic [7:0] reqR = 8'h00;
  logic [7:0] ownL = 8'hFF;
  logic [7:0] ownR = 8'h00;
  logic [7:0] nL, nR, oL, oR;
  logic lAct = 1'h0;
  logic rAct = 1'h0;
  logic lVal = 1'h1;
  logic [15:0] junk = 16'h5A5A;
  wire logic lRd = !pins.tokenSelN && !pins.oeN;
  wire logic rRd = !rSelN && !rOeN;

  always_comb
  begin
    nL = reqL;
    nR = reqR;
    if (!pins.tokenSelN && !pins.rwN) nL[pins.addr[2:0]] = pins.dataOut[0];
    if (!rSelN && !rWrN) nR[rIdx] = rBit;
    oL = ownL & ~nL;
    oR = ownR & ~nR;
    // A same-cycle tie on a free flag goes to the left port.
    for (int i = 0; i < 8; i++)
    begin
      if (!oL[i] && !oR[i] && !nL[i]) oL[i] = 1'h1;
      else if (!oL[i] && !oR[i] && !nR[i]) oR[i] = 1'h1;
    end
  end

  always @(posedge clk)
  begin
    reqL <= nL;
    reqR <= nR;
    ownL <= oL;
    ownR <= oR;
    lAct <= lRd;
    rAct <= rRd;
    junk <= ~junk;
    if (lRd && !lAct) lVal <= ~ownL[pins.addr[2:0]];
    if (rRd && !rAct) rFlag <= ~ownR[rIdx];
  end

  // Outside a read the bus shows a toggling pattern, never the last value.
  assign dataIn = (lRd && lAct) ? {16{lVal}} : junk;
endmodule : dpsf_sem_model
`default_nettype wire

// ===== tb/dpsf_port_ctrl_tb_top.sv
// Self-checking bench for the flag port controller against the device model.
`default_nettype none
module dpsf_port_ctrl_tb_top
  import dpsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int A = 4;
  localparam int G = 2;
  localparam int P = 4;
  localparam int CYC = A + G;
  logic clk, sys_rst, ce, cmdValid, cmdReady, rspValid, rspGranted, ceRand;
  logic rSelN, rWrN, rOeN, rBit, rFlag, g, v;
  logic [2:0] rIdx, f;
  dpsf_cmd_s cmd;
  dpsf_pins_s pins;
  logic [15:0] dataIn;
  int n_mismatch, comparisons, lat, mode, seed;

  dpsf_port_ctrl #(.AccessCycles(A), .GapCycles(G), .MaxPolls(P)) dpsf_port_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
    .ce(ce), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd), .rspValid(rspValid), .rspGranted(rspGranted),
    .pins(pins), .dataIn(dataIn));
  dpsf_sem_model dpsf_sem_model_inst (.clk(clk), .pins(pins), .dataIn(dataIn), .rSelN(rSelN), .rWrN(rWrN),
    .rOeN(rOeN), .rIdx(rIdx), .rBit(rBit), .rFlag(rFlag));

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) ce <= ceRand ? ($urandom % 4 != 0) : 1'h1;

  function automatic logic exp_grant(input int m);
    return m == 0;
  endfunction : exp_grant

  task automatic report_and_stop();
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", name, e, s);
    end
  endtask : check

  task automatic bound(input int k);
    if (k >= 600)
    begin
      n_mismatch++;
      $display("unexpected wait expected done seen timeout");
      report_and_stop();
    end
  endtask : bound

  // Latency counts from the edge that takes the command to the cycle that shows the answer.
  task automatic run_cmd(input dpsf_op_e op, input logic [2:0] fl, output logic gr, output int lt);
    int k;
    k = 0;
    @(posedge clk);
    cmdValid <= 1'h1;
    cmd <= '{op: op, flag: fl};
    do begin @(negedge clk); k++; end while (!(cmdReady === 1'h1 && ce === 1'h1) && k < 600);
    bound(k);
    @(posedge clk);
    cmdValid <= 1'h0;
    lt = 0;
    do begin @(negedge clk); lt++; end while (rspValid !== 1'h1 && lt < 600);
    bound(lt);
    gr = rspGranted;
  endtask : run_cmd

  task automatic r_write(input logic [2:0] i, input logic b);
    @(posedge clk);
    rSelN <= 1'h0;
    rWrN <= 1'h0;
    rIdx <= i;
    rBit <= b;
    @(posedge clk);
    rSelN <= 1'h1;
    rWrN <= 1'h1;
  endtask : r_write

  task automatic r_read(input logic [2:0] i, output logic b);
    @(posedge clk);
    rSelN <= 1'h0;
    rOeN <= 1'h0;
    rIdx <= i;
    @(posedge clk);
    @(negedge clk);
    b = rFlag;
    @(posedge clk);
    rSelN <= 1'h1;
    rOeN <= 1'h1;
  endtask : r_read

  always @(negedge clk)
  begin
    if (sys_rst === 1'h0 && pins.tokenSelN === 1'h0)
    begin
      check("ramSelN", 1, pins.ramSelN);
      check("addrHigh", 0, pins.addr[15:3]);
      if (pins.rwN === 1'h0)
      begin
        check("dataOut", {16{pins.dataOut[0]}}, pins.dataOut);
        check("dataOeN", 0, pins.dataOeN);
      end
    end
  end

  initial
  begin
    {rSelN, rWrN, rOeN, rBit, sys_rst} = 5'h1F;
    {cmdValid, ceRand, rIdx} = 5'h00;
    cmd = '0;
    seed = $urandom(79);
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    @(negedge clk);
    check("idle", 8'hF8, {cmdReady, pins.tokenSelN, pins.oeN, pins.dataOeN, pins.rwN, rspValid, rspGranted, 1'h0});
    run_cmd(OP_INIT, 3'h0, g, lat);
    check("initLat", 8 * CYC + 1, lat);
    check("initGrant", 1, g);
    for (int i = 0; i < 8; i++) r_write(i[2:0], 1'h1);
    for (int i = 0; i < 8; i++)
    begin
      r_read(i[2:0], v);
      check("freeFlag", 1, v);
    end
    run_cmd(OP_ACQUIRE, 3'h3, g, lat);
    check("acqLat", 2 * CYC + 1, lat);
    check("acqGrant", 1, g);
    r_read(3'h3, v);
    check("otherSide", 1, v);
    r_write(3'h3, 1'h0);
    r_read(3'h3, v);
    check("pending", 1, v);
    run_cmd(OP_RELEASE, 3'h3, g, lat);
    check("relLat", CYC + 1, lat);
    check("relGrant", 1, g);
    r_read(3'h3, v);
    check("handOver", 0, v);
    run_cmd(OP_ACQUIRE, 3'h3, g, lat);
    check("failLat", (3 + P) * CYC + 1, lat);
    check("failGrant", 0, g);
    r_write(3'h3, 1'h1);
    r_write(3'h3, 1'h0);
    r_read(3'h3, v);
    check("withdrawn", 0, v);
    r_write(3'h3, 1'h1);
    // Releasing mid-poll shows whether the controller drops select or output enable between reads.
    r_write(3'h6, 1'h0);
    fork
      run_cmd(OP_ACQUIRE, 3'h6, g, lat);
      begin repeat (3 * CYC) @(posedge clk); r_write(3'h6, 1'h1); end
    join
    check("pollGrant", 1, g);
    run_cmd(OP_RELEASE, 3'h6, g, lat);
    ceRand = 1'h1;
    repeat (24)
    begin
      f = 3'($urandom % 8);
      mode = $urandom % 3;
      if (mode == 1) r_write(f, 1'h0);
      if (mode == 2)
      fork
        run_cmd(OP_ACQUIRE, f, g, lat);
        r_write(f, 1'h0);
      join
      else run_cmd(OP_ACQUIRE, f, g, lat);
      r_read(f, v);
      if (mode == 2) check("oneOwner", v, g);
      else check("grant", exp_grant(mode), g);
      run_cmd(OP_RELEASE, f, g, lat);
      r_write(f, 1'h1);
    end
    ceRand = 1'h0;
    report_and_stop();
  end
endmodule : dpsf_port_ctrl_tb_top
`default_nettype wire
